/* File: dv/bus_node_model.sv */
// Other node on the multiplex bus, driving its share of the wired level
`timescale 1ns/1ns
`include "link_cpu_map.svh"
module bus_node_model (
  input wire logic pclk,
  output logic node_level
);
  // Passive high while idle, as the pull-up leaves it
  initial node_level = 1'b1;
  // Data MSB first, one bit time each; the receiver starts on the fall of an active MSB
  task automatic send_byte(input logic [7:0] b);
    @(posedge pclk);
    for (int i = 7; i >= 0; i--) begin
      node_level <= b[i];
      repeat (`BIT_CYCLES) @(posedge pclk);
    end
    node_level <= 1'b1;
    // gap gives reader two bit times
    repeat (2 * `BIT_CYCLES) @(posedge pclk);
  endtask
  // Short active pulse, enough for an edge wake
  task automatic wake_edge();
    @(posedge pclk);
    node_level <= 1'b0;
    repeat (4) @(posedge pclk);
    node_level <= 1'b1;
  endtask
endmodule // bus_node_model

/* File: dv/j1850_link_cpu_interface_test.sv */
// Self-checking bench for the link CPU interface
`timescale 1ns/1ns
`include "link_cpu_map.svh"
module j1850_link_cpu_interface_test;
  import link_cpu_pkg::*;
  localparam logic [7:0] vec_a = `VECTOR_OFFSET;
  localparam logic [7:0] dat_a = `DATA_OFFSET;
  localparam logic [7:0] ctl_a = `CONTROL_OFFSET;
  localparam logic [7:0] sts_a = `STATUS_OFFSET;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, se;
  logic bus_rx_pin, bus_tx_out, bus_tx_oe_n, irq, nmi, clocks_running, node_level;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  link_events_s link_events;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  // Rows: one event, first vector read, second vector read
  logic [4:0] ev [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
  logic [7:0] ex [5] = '{8'h04, 8'h08, 8'h14, 8'h18, 8'h1C};
  logic [7:0] ex2 [5] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00};
  always #50 pclk = ~pclk;
  // Wired bus: either party pulls it active
  assign bus_rx_pin = node_level & (bus_tx_oe_n | bus_tx_out);
  link_cpu_interface u_link_cpu_interface (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_events(link_events), .bus_rx_pin(bus_rx_pin), .bus_tx_out(bus_tx_out), .bus_tx_oe_n(bus_tx_oe_n),
    .irq(irq), .nmi(nmi), .clocks_running(clocks_running));
  bus_node_model u_bus_node_model (.pclk(pclk), .node_level(node_level));
  task summarize;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, far above the eight thousand or so cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      summarize();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // APB transfer; data taken at the edge that samples pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdv(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task pulse(input logic [4:0] e);
    @(posedge pclk);
    link_events <= e;
    @(posedge pclk);
    link_events <= '0;
    @(negedge pclk);
  endtask
  // Reads until the value shows, bounded, then compares
  task poll(input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    rdv(a);
    while (rd !== v && k < 6000) begin
      rdv(a);
      k++;
    end
    chk("poll", rd, v);
  endtask
  // Waits for the transmitter to let go, then runs four rounds of vector read, data read and end-of-data write
  task flush;
    int k;
    k = 0;
    while (bus_tx_oe_n !== 1'b1 && k < 6000) begin
      @(posedge pclk);
      k++;
    end
    chk("tx idle", bus_tx_oe_n, 1'b1);
    repeat (4) begin
      rdv(vec_a);
      rdv(dat_a);
      apb(1'b1, ctl_a, 32'h0000_0001);
    end
  endtask
  initial begin
    int k;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    link_events = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state
    rdv(vec_a);
    chk("vector", rd, 32'h0000_0000);
    rdv(sts_a);
    chk("status", rd, 32'h0000_0004);
    chk("oe_n", bus_tx_oe_n, 1'b1);
    chk("irq", irq, 1'b0);
    chk("pready", pready, 1'b1);
    // Single sources, read clearing per kind
    for (int i = 0; i < 5; i++) begin
      pulse(ev[i]);
      rdv(vec_a);
      chk("vector", rd, ex[i]);
      rdv(vec_a);
      chk("vector", rd, ex2[i]);
      rdv(dat_a);
      rdv(vec_a);
      chk("vector", rd, 32'h0000_0000);
    end
    // Two sources at once: higher first, then the other
    pulse(5'h12);
    rdv(vec_a);
    chk("vector", rd, 32'h0000_0018);
    rdv(vec_a);
    chk("vector", rd, 32'h0000_0004);
    // Interrupt allowed, raised, cleared
    apb(1'b1, ctl_a, 32'h0000_0004);
    pulse(5'h01);
    chk("irq", irq, 1'b1);
    rdv(vec_a);
    @(negedge pclk);
    chk("irq", irq, 1'b0);
    apb(1'b1, ctl_a, 32'h0000_0000);
    // Unmapped place refused
    rdv(8'h40);
    chk("slverr", se, 1'b1);
    chk("rdata", rd, 32'h0000_0000);
    // Transmit two bytes, then end of data
    apb(1'b1, dat_a, 32'h0000_0055);
    poll(vec_a, 32'h0000_0010);
    @(negedge pclk);
    chk("tx out", bus_tx_out, 1'b1);
    apb(1'b1, dat_a, 32'h0000_00C3);
    rdv(vec_a);
    chk("vector", rd, 32'h0000_0000);
    poll(vec_a, 32'h0000_0010);
    apb(1'b1, ctl_a, 32'h0000_0001);
    rdv(vec_a);
    chk("tx wanted", rd == 32'h0000_0010, 1'b0);
    flush();
    // Underrun: byte never refilled
    apb(1'b1, dat_a, 32'h0000_000F);
    poll(vec_a, 32'h0000_0010);
    poll(vec_a, 32'h0000_001C);
    rdv(sts_a);
    chk("underrun", rd[1], 1'b1);
    flush();
    // Receive one byte from the other node
    u_bus_node_model.send_byte(8'h5A);
    poll(vec_a, 32'h0000_000C);
    rdv(dat_a);
    chk("rx data", rd, 32'h0000_005A);
    rdv(vec_a);
    chk("vector", rd, 32'h0000_0000);
    // Wait mode woken by a received byte
    apb(1'b1, ctl_a, 32'h0000_000C);
    rdv(sts_a);
    chk("mode", rd[4:2], 3'b010);
    u_bus_node_model.send_byte(8'h3C);
    poll(vec_a, 32'h0000_000C);
    @(negedge pclk);
    chk("irq", irq, 1'b1);
    rdv(dat_a);
    chk("rx data", rd, 32'h0000_003C);
    rdv(sts_a);
    chk("mode", rd[4:2], 3'b001);
    apb(1'b1, ctl_a, 32'h0000_0000);
    // Stop by stop command, then by wait with clocks stopping
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, ctl_a, (j == 0) ? 32'h0000_0010 : 32'h0000_000A);
      @(negedge pclk);
      chk("clocks", clocks_running, 1'b0);
      rdv(sts_a);
      chk("mode", rd[4:2], 3'b100);
      u_bus_node_model.wake_edge();
      k = 0;
      while (nmi !== 1'b1 && k < 50) begin
        @(negedge pclk);
        k++;
      end
      chk("nmi", nmi, 1'b1);
      poll(vec_a, 32'h0000_0020);
      repeat (40) @(posedge pclk);
      chk("clocks", clocks_running, 1'b1);
      apb(1'b1, ctl_a, 32'h0000_0000);
      flush();
    end
    summarize();
  end
endmodule // j1850_link_cpu_interface_test

/* File: dv/link_cpu_interface_asserts.sv */
// Port checker for the link CPU interface
`timescale 1ns/1ns
`include "link_cpu_map.svh"
module link_cpu_interface_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire link_cpu_pkg::link_events_s link_events,
  input wire logic bus_tx_oe_n,
  input wire logic irq,
  input wire logic nmi,
  input wire logic clocks_running
);
  import link_cpu_pkg::*;
  logic allow_q;
  logic rd_vec;
  logic wr_ctl;
  // Decoded accesses seen in the access phase
  assign rd_vec = psel && penable && !pwrite && paddr == `VECTOR_OFFSET;
  assign wr_ctl = psel && penable && pwrite && paddr == `CONTROL_OFFSET;
  // Own copy of irq_allow, so irq is judged against what software wrote
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      allow_q <= 1'b0;
    end else if (wr_ctl) begin
      allow_q <= pwdata[`CTRL_IRQ_ALLOW_BIT];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_vec_aligned: assert property (rd_vec |-> prdata[1:0] == 2'h0 && prdata[31:6] == '0)
    else $error("vector read has bits outside the code field");
  a_vec_range: assert property (rd_vec |-> prdata[5:2] <= 4'h8)
    else $error("vector code above the highest source");
  a_wait_quiet: assert property (wr_ctl && pwdata[3] && !pwdata[1] && !pwdata[4] |=> bus_tx_oe_n [*8])
    else $error("bus driven in wait mode");
  a_stop_enter: assert property (wr_ctl && (pwdata[4] || pwdata[3] && pwdata[1]) |-> ##[1:2] !clocks_running)
    else $error("stop command left clocks running");
  a_irq_allowed: assert property (irq |-> allow_q)
    else $error("irq raised while not allowed");
  a_event_irq: assert property (link_events.invalid && allow_q && clocks_running && !wr_ctl |=> irq)
    else $error("invalid symbol event gave no irq");
  a_nmi_stop: assert property (nmi |-> !clocks_running)
    else $error("nmi outside stop wake");
  a_restart_bound: assert property ($rose(nmi) |-> ##[1:40] clocks_running)
    else $error("clocks did not restart after wake");
endmodule // link_cpu_interface_asserts
bind link_cpu_interface link_cpu_interface_asserts u_link_cpu_interface_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .link_events(link_events), .bus_tx_oe_n(bus_tx_oe_n), .irq(irq), .nmi(nmi), .clocks_running(clocks_running));

/* File: hdl/link_cpu_interface.sv */
// CPU side of a byte link controller: vector, data buffers, underrun and power modes
// Function
// - Vector reads as four-bit source code times four; zero when nothing pending.
// - Highest pending source wins: wakeup, invalid, CRC, arbitration, tx, rx, response, EOF.
// - Vector read clears reported source except rx ready, response and tx wanted.
// - Rx ready and response clear after vector read then data read.
// - Tx wanted clears after vector read then data write, or end-of-data bit.
// - After clearing a source the next pending lower source is shown.
// - Data read returns the latest received byte.
// - Finished shift register reloads from the tx shadow register.
// - Tx wanted sets once the first bit of a byte has been sent.
// - Completed rx byte copies into rx shadow and sets rx ready.
// - Rx shadow is overwritten by the next byte after one byte time.
// - Missing tx byte flags underrun, sends two ones, then disables transmitter.
// - Halted transmission reports as invalid symbol error.
// - Wait with wait_stops_clocks clear enters wait mode; no data driven.
// - Wait mode: received message wakes, is received, interrupts if allowed.
// - Stop command, or wait with wait_stops_clocks set, enters stop mode.
// - In stop mode a passive-to-active bus edge wakes and raises nmi.
// - Wait-entered stop receives waking byte only if EOF seen before.
// - Stop during reception: first edge wakes at once, resumes after restart.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "link_cpu_map.svh"
module link_cpu_interface (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire link_cpu_pkg::link_events_s link_events,
  input wire logic bus_rx_pin,
  output logic bus_tx_out,
  output logic bus_tx_oe_n,
  output logic irq,
  output logic nmi,
  output logic clocks_running
);
  import link_cpu_pkg::*;

  logic [7:0] control_reg;
  logic vector_armed_reg;
  source_code_e armed_code_reg;
  logic [7:0] rx_shadow_reg;
  logic [7:0] tx_shadow_reg;
  logic tx_shadow_full_reg;
  logic [7:0] tx_shift_reg;
  logic [3:0] tx_bits_reg;
  logic [15:0] bit_cnt_reg;
  tx_state_e tx_state_reg;
  logic [7:0] rx_shift_reg;
  logic [3:0] rx_bits_reg;
  logic rx_ready_reg;
  logic response_reg;
  logic tx_wanted_reg;
  logic eof_reg, arb_reg, crc_reg, invalid_reg, wakeup_reg;
  logic underrun_reg;
  logic eof_seen_reg;
  logic stop_via_wait_reg;
  logic rx_active_reg;
  power_mode_e mode_reg;
  logic [15:0] restart_cnt_reg;
  logic [2:0] rx_sync_reg;
  logic rx_level_reg;
  source_code_e code;
  logic wr, rd, rd_vec, rd_data, wr_data, wr_ctrl;
  logic bit_tick, rx_fall, rx_done, tx_first_bit, tx_load;

  // APB decode; zero wait states
  // Every register answers in the access cycle, so pready never drops
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign rd_vec = rd && paddr == `VECTOR_OFFSET;
  assign rd_data = rd && paddr == `DATA_OFFSET;
  assign wr_data = wr && paddr == `DATA_OFFSET;
  assign wr_ctrl = wr && paddr == `CONTROL_OFFSET;
  // Unmapped addresses answer with an error
  // Writes there are dropped, reads give zero
  assign pslverr = psel & penable & ~(paddr == `VECTOR_OFFSET || paddr == `DATA_OFFSET ||
    paddr == `CONTROL_OFFSET || paddr == `STATUS_OFFSET || paddr == `EVENT_OFFSET);

  // Priority encoder
  // Combinational so a clear shows the next source in the very next cycle
  // fixed priority order
  // lower source shows once higher clears
  always_comb begin
    if (wakeup_reg) code = SRC_WAKEUP;
    else if (invalid_reg) code = SRC_INVALID;
    else if (crc_reg) code = SRC_CRC;
    else if (arb_reg) code = SRC_ARB_LOST;
    else if (tx_wanted_reg) code = SRC_TX_WANTED;
    else if (rx_ready_reg) code = SRC_RX_READY;
    else if (response_reg) code = SRC_RESPONSE;
    else if (eof_reg) code = SRC_EOF;
    else code = SRC_NONE;
  end

  // Read mux
  // Status packs mode, underrun and tx shadow full for software polling
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      `VECTOR_OFFSET: prdata = {26'h000_0000, code, 2'b00};
      `DATA_OFFSET: prdata = {24'h00_0000, rx_shadow_reg};
      `CONTROL_OFFSET: prdata = {24'h00_0000, control_reg};
      `STATUS_OFFSET: prdata = {27'h000_0000, mode_reg, underrun_reg, tx_shadow_full_reg};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // Control register; end-of-data bit self clears
  // Commands are not stored; only the power mode remembers them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= `CONTROL_RESET;
    end else if (wr_ctrl) begin
      control_reg <= pwdata[7:0] & 8'h07;
    end else begin
      control_reg[`CTRL_TX_END_BIT] <= 1'b0;
    end
  end

  // Remember which service-type code the last vector read returned
  // Guards against a stray data access clearing a flag software never saw
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_armed_reg <= 1'b0;
      armed_code_reg <= SRC_NONE;
    end else if (rd_vec) begin
      vector_armed_reg <= 1'b1;
      armed_code_reg <= code;
    end else if (rd_data || wr_data) begin
      vector_armed_reg <= 1'b0;
    end
  end

  // Three-stage synchroniser on the bus pin; change taken when stages 2 and 3 agree
  // Reset to the passive level so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync_reg <= 3'b111;
      rx_level_reg <= 1'b1;
    end else begin
      rx_sync_reg <= {rx_sync_reg[1:0], bus_rx_pin};
      if (rx_sync_reg[1] == rx_sync_reg[2]) rx_level_reg <= rx_sync_reg[2];
    end
  end
  // Passive high, active low
  assign rx_fall = rx_level_reg && rx_sync_reg[1] == rx_sync_reg[2] && !rx_sync_reg[2];

  // Bit timer; sample and shift once per bit time
  // Shared by both directions; a receive start also realigns the transmitter
  assign bit_tick = bit_cnt_reg == 16'(`BIT_CYCLES - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bit_cnt_reg <= 16'h0000;
    else if (bit_tick || (rx_fall && !rx_active_reg)) bit_cnt_reg <= 16'h0000;
    else bit_cnt_reg <= bit_cnt_reg + 16'h0001;
  end

  // Receiver; byte assembles from the bus while clocks run
  // Limitation: the fall of an active MSB is the only start mark of a byte
  // receive continues in wait mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift_reg <= 8'h00;
      rx_bits_reg <= 4'h0;
      rx_active_reg <= 1'b0;
    end else if (mode_reg == MODE_STOP) begin
      // Frame state lost while clocks stand
      rx_bits_reg <= 4'h0;
      rx_active_reg <= stop_via_wait_reg & eof_seen_reg & rx_fall;
    end else if (rx_fall && !rx_active_reg) begin
      rx_active_reg <= 1'b1;
      rx_bits_reg <= 4'h0;
    end else if (rx_active_reg && bit_tick) begin
      rx_shift_reg <= {rx_shift_reg[6:0], rx_level_reg};
      rx_bits_reg <= (rx_bits_reg == 4'h7) ? 4'h0 : rx_bits_reg + 4'h1;
      if (rx_bits_reg == 4'h7) rx_active_reg <= 1'b0;
    end
  end
  assign rx_done = rx_active_reg && bit_tick && rx_bits_reg == 4'h7 && mode_reg != MODE_STOP;

  // Receive shadow
  // copy completed byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_shadow_reg <= 8'h00;
    else if (rx_done) rx_shadow_reg <= {rx_shift_reg[6:0], rx_level_reg};
  end

  // Service flags; set wins over clear
  // A flag set in the clearing cycle survives, so no byte is missed
  // vector read then data read
  // vector read then data write, or end of data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ready_reg <= 1'b0;
      response_reg <= 1'b0;
      tx_wanted_reg <= 1'b0;
    end else begin
      if (rx_done) rx_ready_reg <= 1'b1;
      else if (rd_data && vector_armed_reg && armed_code_reg == SRC_RX_READY) rx_ready_reg <= 1'b0;
      if (link_events.response) response_reg <= 1'b1;
      else if (rd_data && vector_armed_reg && armed_code_reg == SRC_RESPONSE) response_reg <= 1'b0;
      if (tx_first_bit) tx_wanted_reg <= 1'b1;
      else if ((wr_data && vector_armed_reg && armed_code_reg == SRC_TX_WANTED) ||
               control_reg[`CTRL_TX_END_BIT]) tx_wanted_reg <= 1'b0;
    end
  end

  // Read-cleared flags
  // Only the code shown by the read is cleared; lower sources stay pending
  // vector read clears reported code
  // halted transmission seen as invalid symbol
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eof_reg <= 1'b0;
      arb_reg <= 1'b0;
      crc_reg <= 1'b0;
      invalid_reg <= 1'b0;
      wakeup_reg <= 1'b0;
    end else begin
      if (link_events.eof) eof_reg <= 1'b1;
      else if (rd_vec && code == SRC_EOF) eof_reg <= 1'b0;
      if (link_events.arb_lost) arb_reg <= 1'b1;
      else if (rd_vec && code == SRC_ARB_LOST) arb_reg <= 1'b0;
      if (link_events.crc_err) crc_reg <= 1'b1;
      else if (rd_vec && code == SRC_CRC) crc_reg <= 1'b0;
      if (link_events.invalid || (tx_state_reg == TX_PAD && bit_tick && tx_bits_reg == 4'h1))
        invalid_reg <= 1'b1;
      else if (rd_vec && code == SRC_INVALID) invalid_reg <= 1'b0;
      if ((mode_reg == MODE_WAIT && rx_done) || (mode_reg == MODE_STOP && rx_fall)) wakeup_reg <= 1'b1;
      else if (rd_vec && code == SRC_WAKEUP) wakeup_reg <= 1'b0;
    end
  end

  // End of frame memory for wait-entered stop
  // Any new frame start in run mode forgets the end of frame
  // waking byte kept only after EOF
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) eof_seen_reg <= 1'b0;
    else if (link_events.eof) eof_seen_reg <= 1'b1;
    else if (rx_fall && mode_reg == MODE_RUN) eof_seen_reg <= 1'b0;
  end

  // Transmit shadow; filled by data write
  // A write in the load cycle keeps the new byte while the old one goes out
  assign tx_load = (tx_state_reg == TX_IDLE || (tx_state_reg == TX_SHIFT && bit_tick && tx_bits_reg == 4'h7))
    && tx_shadow_full_reg && mode_reg == MODE_RUN;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shadow_reg <= 8'h00;
      tx_shadow_full_reg <= 1'b0;
    end else if (wr_data) begin
      tx_shadow_reg <= pwdata[7:0];
      tx_shadow_full_reg <= 1'b1;
    end else if (tx_load) begin
      tx_shadow_full_reg <= 1'b0;
    end
  end
  assign tx_first_bit = tx_state_reg == TX_SHIFT && bit_tick && tx_bits_reg == 4'h0;

  // Transmitter state machine
  // End of data must be set before the last byte ends, else underrun
  // shadow moves into shift register
  // underrun pads two ones then halts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 8'h00;
      tx_bits_reg <= 4'h0;
      underrun_reg <= 1'b0;
    end else begin
      unique case (tx_state_reg)
        TX_IDLE: begin
          if (tx_load) begin
            tx_shift_reg <= tx_shadow_reg;
            tx_bits_reg <= 4'h0;
            underrun_reg <= 1'b0;
            tx_state_reg <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (bit_tick) begin
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
            tx_bits_reg <= tx_bits_reg + 4'h1;
            if (tx_bits_reg == 4'h7) begin
              tx_bits_reg <= 4'h0;
              if (tx_load) tx_shift_reg <= tx_shadow_reg;
              else if (control_reg[`CTRL_TX_END_BIT] || !tx_wanted_reg) tx_state_reg <= TX_IDLE;
              else begin
                underrun_reg <= 1'b1;
                tx_state_reg <= TX_PAD;
              end
            end
          end
        end
        TX_PAD: begin
          // Two ones break the byte boundary
          if (bit_tick) begin
            tx_bits_reg <= tx_bits_reg + 4'h1;
            if (tx_bits_reg == 4'h1) tx_state_reg <= TX_HALT;
          end
        end
        TX_HALT: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // Bus drive; open drain, low enable drives
  // Registered so the pin never glitches while the state changes
  // nothing driven outside run mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_tx_out <= 1'b0;
      bus_tx_oe_n <= 1'b1;
    end else begin
      bus_tx_out <= (tx_state_reg == TX_PAD) ? 1'b1 : tx_shift_reg[7];
      bus_tx_oe_n <= !((tx_state_reg == TX_SHIFT || tx_state_reg == TX_PAD) && mode_reg == MODE_RUN);
    end
  end

  // Power mode machine; wait/stop commands come as control bits
  // Wait also wakes on any allowed interrupt, not only on a received byte
  // wake at once, resume after restart count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= MODE_RUN;
      stop_via_wait_reg <= 1'b0;
      restart_cnt_reg <= 16'h0000;
    end else begin
      if (restart_cnt_reg != 16'h0000) restart_cnt_reg <= restart_cnt_reg - 16'h0001;
      unique case (mode_reg)
        MODE_RUN: begin
          if (wr_ctrl && pwdata[`CTRL_STOP_CMD_BIT]) begin
            mode_reg <= MODE_STOP;
            stop_via_wait_reg <= 1'b0;
          end else if (wr_ctrl && pwdata[`CTRL_WAIT_CMD_BIT]) begin
            mode_reg <= pwdata[`CTRL_WAIT_STOPS_BIT] ? MODE_STOP : MODE_WAIT;
            stop_via_wait_reg <= pwdata[`CTRL_WAIT_STOPS_BIT];
          end
        end
        MODE_WAIT: if (wakeup_reg || irq) mode_reg <= MODE_RUN;
        MODE_STOP: begin
          if (rx_fall) begin
            mode_reg <= MODE_RUN;
            restart_cnt_reg <= 16'(`STOP_RESTART_CYCLES);
          end
        end
        default: mode_reg <= MODE_RUN;
      endcase
    end
  end

  // Outputs
  // The nmi only covers the restart count; the vector keeps the wake for software
  // interrupt only when allowed
  assign irq = control_reg[`CTRL_IRQ_ALLOW_BIT] && code != SRC_NONE && mode_reg != MODE_STOP;
  assign nmi = wakeup_reg && restart_cnt_reg != 16'h0000;
  assign clocks_running = mode_reg != MODE_STOP && restart_cnt_reg == 16'h0000;
endmodule // link_cpu_interface

/* File: hdl/link_cpu_map.svh */
// Register offsets, field positions and timing counts for the link CPU interface
`ifndef LINK_CPU_MAP_SVH
`define LINK_CPU_MAP_SVH
`define VECTOR_OFFSET 8'h00
`define DATA_OFFSET 8'h04
`define CONTROL_OFFSET 8'h08
`define STATUS_OFFSET 8'h0C
`define EVENT_OFFSET 8'h10
`define CTRL_TX_END_BIT 0
`define CTRL_WAIT_STOPS_BIT 1
`define CTRL_IRQ_ALLOW_BIT 2
`define CTRL_WAIT_CMD_BIT 3
`define CTRL_STOP_CMD_BIT 4
`define CONTROL_RESET 8'h00
`define VECTOR_SHIFT 2
`define BIT_TIME_NS 15600
`define CLK_PERIOD_NS 100
`define BIT_CYCLES ((`BIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STOP_RESTART_NS 2000
`define STOP_RESTART_CYCLES ((`STOP_RESTART_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: hdl/link_cpu_pkg.sv */
// Types for the link CPU interface
package link_cpu_pkg;
  // Interrupt source codes, priority rising with value
  typedef enum logic [3:0] {
    SRC_NONE = 4'h0,
    SRC_EOF = 4'h1,
    SRC_RESPONSE = 4'h2,
    SRC_RX_READY = 4'h3,
    SRC_TX_WANTED = 4'h4,
    SRC_ARB_LOST = 4'h5,
    SRC_CRC = 4'h6,
    SRC_INVALID = 4'h7,
    SRC_WAKEUP = 4'h8
  } source_code_e;
  // Power modes, one-hot
  typedef enum logic [2:0] {
    MODE_RUN = 3'b001,
    MODE_WAIT = 3'b010,
    MODE_STOP = 3'b100
  } power_mode_e;
  // Transmitter states, one-hot
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_SHIFT = 4'b0010,
    TX_PAD = 4'b0100,
    TX_HALT = 4'b1000
  } tx_state_e;
  // Events from the symbol layer
  typedef struct packed {
    logic eof;
    logic response;
    logic arb_lost;
    logic crc_err;
    logic invalid;
  } link_events_s;
endpackage
